// [logic/srw_core.sv]
`timescale 1ns/1ns
module srw_core import srw_pkg::*; #(
	parameter int unsigned RST_CYC = RST_STRETCH_CYC,
	parameter int unsigned NREQ_CYC = NREQ_TIMEOUT_CYC,
	parameter int unsigned WD_INT = WD_INT_CYC,
	parameter int unsigned WD_EXT = WD_EXT_CYC_DEF,
	parameter int unsigned CYC_UNIT = CYC_UNIT_CYC_DEF,
	parameter logic [15:0] LIN_FILT = LIN_WAKE_CYC_DEF
) (
	input wire logic i_ref_clk,
	input wire logic i_rst,
	input wire logic i_lin_clk,
	input wire logic i_lin_rst,
	input wire logic i_lin_rx,
	input wire logic i_vdd_low,
	input wire logic i_reg_overtemp,
	input wire logic i_supply_overvoltage_level,
	input wire logic i_temp_prewarn,
	input wire logic [2:0] i_lin_faults,
	input wire logic i_lin_overcurrent,
	input wire logic i_hs_overtemp,
	input wire logic i_ls_overtemp,
	input wire logic i_rst_pin,
	input wire logic i_cs_n,
	input wire logic [1:0] i_wake_input_pins,
	input wire logic i_pwm_input_pin,
	input wire logic i_hs_open_load,
	input wire logic i_hs_current_limit,
	input wire logic [1:0] i_watchdog_config_pin,
	input wire logic i_mode_wr,
	input wire logic [1:0] i_mode_select_bits,
	input wire logic i_timing_wr,
	input wire logic [1:0] i_wd_prescale,
	input wire logic i_cyclic_or_watchdog_select,
	input wire logic [2:0] i_cyclic_period_bits,
	input wire logic [1:0] i_wake_input_enable,
	input wire logic [1:0] i_mux_select,
	input wire logic i_highside_switch,
	input wire logic i_highside_pwm_select,
	input wire logic i_status_rd,
	input wire logic i_lin_status_rd,
	input wire logic i_irq_ack,
	output logic o_rst_pin_out,
	output logic o_rst_pin_oe,
	output logic o_irq_n,
	output logic [2:0] o_mode,
	output logic o_reg_enable,
	output logic o_regulator_overtemp_flag,
	output logic o_supply_ov_flag,
	output logic o_prewarn_flag,
	output logic o_lin_drv_enable,
	output logic [2:0] o_lin_fault_flags,
	output logic o_lin_overcurrent_flag,
	output logic o_hs_ot_cause,
	output logic o_ls_ot_cause,
	output logic o_watchdog_off_flag,
	output logic o_wd_config_fault,
	output logic [1:0] o_wakeup_status,
	output logic [2:0] o_wake_source,
	output logic o_highside_switch,
	output logic o_highside_open_load_flag,
	output logic o_highside_current_limit_flag
);

	typedef struct packed {
		srw_mode_t mode;
		logic [NSYNC-1:0] s1;
		logic [NSYNC-1:0] s2;
		logic [2:0] lw;
		logic [31:0] cnt;
		logic [31:0] lp;
		logic [7:0] glt;
		logic ext_rst;
		logic wd_off;
		logic wd_fault;
		logic [1:0] presc;
		logic cyc_sel;
		logic [2:0] cyc_per;
		logic [1:0] wref;
		logic [1:0] wmask;
		logic [1:0] wchg;
		logic cs_prev;
		logic reg_ot_f;
		logic ov_f;
		logic pw_f;
		logic oc_f;
		logic hs_ot_f;
		logic ls_ot_f;
		logic [2:0] lin_flt;
		logic [2:0] wsrc;
		logic irq;
		logic hs;
		logic arm;
	} srw_state_t;

	srw_state_t q, n;
	logic lin_tgl;
	logic [NSYNC-1:0] pins;
	logic [31:0] wd_per;
	logic [31:0] lp_per;
	logic cyclic;
	logic forced;
	logic lin_ev;
	logic [1:0] chg;
	logic lp_end;
	logic wake_irq;
	logic wake_rst;
	logic wake_silent;
	logic [2:0] src;
	logic [7:0] new_ev;
	logic [7:0] old_ev;

	////////////////////////////////////////////////////////////////////////
	// Link side lives in its own module on the LIN clock
	srw_lin_wake #(
		.FILT(LIN_FILT)
	) u_lin_wake (
		.i_lin_clk(i_lin_clk),
		.i_lin_rst(i_lin_rst),
		.i_lin_rx(i_lin_rx),
		.i_arm(q.arm),
		.o_wake_tgl(lin_tgl)
	);

	// All pin inputs except the LIN receive line gathered for the two-stage synchroniser
	assign pins = {i_watchdog_config_pin, i_hs_current_limit, i_hs_open_load,
		i_pwm_input_pin, i_wake_input_pins, i_cs_n, i_rst_pin, i_ls_overtemp,
		i_hs_overtemp, i_lin_overcurrent, i_lin_faults, i_temp_prewarn,
		i_supply_overvoltage_level, i_reg_overtemp, i_vdd_low};

	// Timebase choice and prescaler; period grows in powers of two
	assign wd_per = (q.wd_fault ? 32'(WD_INT) : 32'(WD_EXT)) << q.presc;
	assign lp_per = 32'(CYC_UNIT) * {29'h0000_0000, q.cyc_per} + 32'(CYC_UNIT);
	assign cyclic = q.cyc_sel && i_highside_switch;
	assign forced = q.cyc_sel && !i_highside_switch;
	assign lin_ev = q.lw[1] ^ q.lw[2];
	assign chg = (q.s2[SX_WAKE +: 2] ^ q.wref) & q.wmask;
	assign lp_end = q.lp == lp_per - 32'h0000_0001;
	assign old_ev = {q.lin_flt, q.oc_f, q.hs_ot_f, q.ls_ot_f, q.ov_f, q.pw_f};
	assign new_ev = {n.lin_flt, n.oc_f, n.hs_ot_f, n.ls_ot_f, n.ov_f, n.pw_f} & ~old_ev;

	////////////////////////////////////////////////////////////////////////
	// Wake sources while in a low-power mode
	always_comb begin
		src = 3'h0;
		wake_silent = 1'b0;
		if (q.mode == M_STOP || q.mode == M_SLEEP) begin
			if (!cyclic && chg != 2'h0)
				src[WS_LX] = 1'b1;
			if (cyclic && lp_end && (q.wchg | chg) != 2'h0)
				src[WS_LX] = 1'b1; // Wake only at period end
			if (forced && lp_end)
				src[WS_TMR] = 1'b1;
			if (lin_ev)
				src[WS_LIN] = 1'b1;
			if (q.mode == M_STOP && q.s2[SX_CS] && !q.cs_prev)
				wake_silent = 1'b1;
		end
		wake_irq = (q.mode == M_STOP) && (src != 3'h0);
		wake_rst = (q.mode == M_SLEEP) && (src != 3'h0);
	end

	////////////////////////////////////////////////////////////////////////
	// Next state of the whole supervisor
	always_comb begin
		n = q;
		n.s1 = pins;
		n.s2 = q.s1;
		n.lw = {q.lw[1:0], lin_tgl};
		n.cs_prev = q.s2[SX_CS];
		n.arm = (q.mode == M_STOP) || (q.mode == M_SLEEP);

		// Host configuration strobes
		if (i_timing_wr) begin
			n.presc = i_wd_prescale;
			n.cyc_sel = i_cyclic_or_watchdog_select;
			n.cyc_per = i_cyclic_period_bits;
		end

		// Sticky event flags; a new event wins over a clearing read
		n.reg_ot_f = q.s2[SX_REGOT] | (q.reg_ot_f & ~i_status_rd);
		n.ov_f = q.s2[SX_OV] | (q.ov_f & ~i_status_rd);
		n.pw_f = q.s2[SX_PW] | (q.pw_f & ~i_status_rd);
		n.hs_ot_f = q.s2[SX_HSOT] | (q.hs_ot_f & ~i_status_rd);
		n.ls_ot_f = q.s2[SX_LSOT] | (q.ls_ot_f & ~i_status_rd);
		// Latched LIN faults clear only on a read with the fault gone
		n.lin_flt = q.s2[SX_LINF +: 3] | (q.lin_flt & {3{~i_lin_status_rd}});
		n.oc_f = q.s2[SX_OC] | (q.oc_f & ~i_lin_status_rd);
		n.wsrc = q.wsrc & {3{~i_status_rd}};

		// External reset filter, only while we are not driving the line
		if (q.s2[SX_RST] || (q.mode == M_RESET && !q.ext_rst))
			n.glt = 8'h00;
		else if (q.glt != GLITCH_CYC)
			n.glt = q.glt + 8'h01;

		n.cnt = q.cnt + 32'h0000_0001;
		n.lp = q.lp + 32'h0000_0001;

		unique case (q.mode)
			M_RESET: begin
				// Configuration pin is only looked at here
				n.wd_off = q.s2[SX_WDC +: 2] == WDC_GROUND;
				n.wd_fault = q.s2[SX_WDC +: 2] != WDC_GROUND
					&& q.s2[SX_WDC +: 2] != WDC_RESISTOR;
				if (q.ext_rst) begin
					// Release of an external reset leaves at once
					if (q.s2[SX_RST]) begin
						n.ext_rst = 1'b0;
						n.mode = q.wd_off ? M_NORMAL : M_NREQ;
						n.cnt = 32'h0000_0000;
					end
				end else if (q.s2[SX_VDDL]) begin
					n.cnt = 32'h0000_0000; // Stretch restarts while low
				end else if (q.cnt >= 32'(RST_CYC) - 32'h0000_0001) begin
					n.mode = n.wd_off ? M_NORMAL : M_NREQ;
					n.cnt = 32'h0000_0000;
				end
			end
			M_NREQ: begin
				if (i_mode_wr && i_mode_select_bits == MSEL_NORMAL) begin
					n.mode = M_NORMAL;
					n.cnt = 32'h0000_0000;
				end else if (q.cnt >= 32'(NREQ_CYC) - 32'h0000_0001) begin
					n.mode = M_RESET;
					n.cnt = 32'h0000_0000;
				end
			end
			M_NORMAL: begin
				if (i_mode_wr && i_mode_select_bits != MSEL_NORMAL
						&& i_mode_select_bits != 2'h3) begin
					n.mode = i_mode_select_bits == MSEL_STOP ? M_STOP : M_SLEEP;
					n.lp = 32'h0000_0000;
					n.wref = q.s2[SX_WAKE +: 2];
					// Inputs routed to the multiplexer lose wake ability
					n.wmask = i_wake_input_enable & ~i_mux_select;
					n.wchg = 2'h0;
				end else if (q.wd_off) begin
					n.cnt = 32'h0000_0000;
				end else if (i_mode_wr && i_mode_select_bits == MSEL_NORMAL) begin
					// Watchdog service through the mode bits
					if (q.cnt < (wd_per >> 1))
						n.mode = M_RESET; // Closed window
					n.cnt = 32'h0000_0000;
				end else if (q.cnt >= wd_per - 32'h0000_0001) begin
					n.mode = M_RESET; // Run-away software
					n.cnt = 32'h0000_0000;
				end
			end
			M_STOP, M_SLEEP: begin
				if (lp_end) begin
					n.lp = 32'h0000_0000;
					n.wchg = 2'h0;
				end else if (q.lp < HS_PULSE_CYC) begin
					n.wchg = q.wchg | chg; // Sampled while the switch is on
				end
				if (wake_irq || wake_silent) begin
					n.mode = M_NREQ;
					n.cnt = 32'h0000_0000;
				end else if (wake_rst) begin
					n.mode = M_RESET; // Like a power-up
					n.cnt = 32'h0000_0000;
				end
				n.wsrc = q.wsrc | src;
			end
			default: begin
				n.mode = M_RESET;
				n.cnt = 32'h0000_0000;
			end
		endcase

		// Filtered external reset overrides every mode except sleep, stop included
		if (q.glt == GLITCH_CYC && !q.ext_rst && q.mode != M_SLEEP) begin
			n.mode = M_RESET;
			n.ext_rst = 1'b1;
			n.cnt = 32'h0000_0000;
		end
		// Brown-out forces and holds reset, even past an external release; ignored in sleep
		if (q.s2[SX_VDDL] && q.mode != M_SLEEP) begin
			n.mode = M_RESET;
			n.cnt = 32'h0000_0000;
		end

		// Interrupt line: set by events, released by the acknowledge read
		if (n.mode == M_RESET)
			n.irq = 1'b0;
		else if (wake_irq || ((q.mode == M_NREQ || q.mode == M_NORMAL) && new_ev != 8'h00))
			n.irq = 1'b1;
		else if (i_irq_ack)
			n.irq = 1'b0;

		// Switch output: bit, bit gated by PWM, or the cyclic pulse
		if (q.mode == M_NREQ || q.mode == M_NORMAL)
			n.hs = i_highside_switch && !q.s2[SX_HSOT]
				&& (!i_highside_pwm_select || q.s2[SX_PWM]);
		else if (q.mode == M_STOP || q.mode == M_SLEEP)
			n.hs = cyclic && (q.lp < HS_PULSE_CYC);
		else
			n.hs = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Single state register
	always_ff @(posedge i_ref_clk) begin
		if (i_rst)
			q <= '{mode: M_RESET, s1: SYNC_IDLE, s2: SYNC_IDLE, cs_prev: 1'b1, default: '0};
		else
			q <= n;
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign o_rst_pin_out = 1'b0;
	assign o_rst_pin_oe = q.mode == M_RESET && !q.ext_rst;
	assign o_irq_n = ~q.irq;
	assign o_mode = q.mode;
	assign o_reg_enable = q.mode != M_SLEEP && !q.reg_ot_f;
	assign o_regulator_overtemp_flag = q.reg_ot_f;
	assign o_supply_ov_flag = q.ov_f;
	assign o_prewarn_flag = q.pw_f;
	assign o_lin_drv_enable = q.lin_flt == 3'h0; // Overcurrent not included
	assign o_lin_fault_flags = q.lin_flt;
	assign o_lin_overcurrent_flag = q.oc_f;
	assign o_hs_ot_cause = q.hs_ot_f;
	assign o_ls_ot_cause = q.ls_ot_f;
	assign o_watchdog_off_flag = q.wd_off;
	assign o_wd_config_fault = q.wd_fault;
	assign o_wakeup_status = q.s2[SX_WAKE +: 2];
	assign o_wake_source = q.wsrc;
	assign o_highside_switch = q.hs;
	assign o_highside_open_load_flag = q.s2[SX_HSOL];
	assign o_highside_current_limit_flag = q.s2[SX_HSCL];

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_rst);

	sequence s_stop_cs_rise;
		q.mode == M_STOP && q.s2[SX_CS] && !q.cs_prev && q.glt != GLITCH_CYC
			&& !q.s2[SX_VDDL];
	endsequence
	sequence s_early_clear;
		q.mode == M_NORMAL && !q.wd_off && i_mode_wr
			&& i_mode_select_bits == MSEL_NORMAL && q.cnt < (wd_per >> 1);
	endsequence

	property p_rst_stretch;
		q.mode == M_RESET && !q.ext_rst && !q.s2[SX_VDDL] && q.glt != GLITCH_CYC
			&& q.cnt < 32'(RST_CYC) - 32'h0000_0001 |=> q.mode == M_RESET && o_rst_pin_oe;
	endproperty
	a_rst_stretch: assert property (p_rst_stretch)
		else $error("Reset released early");

	property p_brownout;
		q.s2[SX_VDDL] && q.mode != M_SLEEP |=> q.mode == M_RESET;
	endproperty
	a_brownout: assert property (p_brownout)
		else $error("Brown-out did not reset");

	property p_reg_ot;
		q.s2[SX_REGOT] |=> !o_reg_enable && o_regulator_overtemp_flag;
	endproperty
	a_reg_ot: assert property (p_reg_ot)
		else $error("Regulator not shut on overtemp");

	property p_lin_oc_only;
		q.lin_flt == 3'h0 && q.s2[SX_LINF +: 3] == 3'h0 && q.s2[SX_OC]
			|=> o_lin_drv_enable && o_lin_overcurrent_flag;
	endproperty
	a_lin_oc_only: assert property (p_lin_oc_only)
		else $error("Overcurrent disabled driver");

	property p_early_clear;
		s_early_clear |=> q.mode == M_RESET;
	endproperty
	a_early_clear: assert property (p_early_clear)
		else $error("Closed-window clear accepted");

	property p_nreq_timeout;
		q.mode == M_NREQ && q.cnt == 32'(NREQ_CYC) - 32'h0000_0001 && !i_mode_wr
			|=> q.mode == M_RESET;
	endproperty
	a_nreq_timeout: assert property (p_nreq_timeout)
		else $error("Request timeout missed");

	property p_cs_wake;
		s_stop_cs_rise ##0 !wake_irq |=> q.mode == M_NREQ && o_irq_n == $past(o_irq_n);
	endproperty
	a_cs_wake: assert property (p_cs_wake)
		else $error("Chip-select wake wrong");

	property p_irq_hold;
		!o_irq_n && !i_irq_ack && n.mode != M_RESET |=> !o_irq_n;
	endproperty
	a_irq_hold: assert property (p_irq_hold)
		else $error("Interrupt dropped without ack");

	property p_wd_off;
		q.mode == M_RESET && q.s2[SX_WDC +: 2] == WDC_GROUND |=> o_watchdog_off_flag;
	endproperty
	a_wd_off: assert property (p_wd_off)
		else $error("Watchdog-off flag not set");

endmodule

// [logic/srw_pkg.sv]
package srw_pkg;

	localparam int CLK_MHZ = 250;
	localparam real RST_STRETCH_MS = 1.0;
	localparam int RST_STRETCH_CYC = int'(RST_STRETCH_MS * 1000.0 * CLK_MHZ);
	localparam real NREQ_TIMEOUT_MS = 150.0;
	localparam int NREQ_TIMEOUT_CYC = int'(NREQ_TIMEOUT_MS * 1000.0 * CLK_MHZ);
	localparam real WD_INT_MS = 150.0;
	localparam int WD_INT_CYC = int'(WD_INT_MS * 1000.0 * CLK_MHZ);
	localparam int WD_EXT_CYC_DEF = 37500000;
	localparam int CYC_UNIT_CYC_DEF = 2500000;
	localparam logic [31:0] HS_PULSE_CYC = 32'h0000_0040;
	localparam logic [7:0] GLITCH_CYC = 8'h10;
	localparam logic [15:0] LIN_WAKE_CYC_DEF = 16'h0100;

	// Mode select codes written by the host
	localparam logic [1:0] MSEL_NORMAL = 2'h0;
	localparam logic [1:0] MSEL_STOP = 2'h1;
	localparam logic [1:0] MSEL_SLEEP = 2'h2;

	// Watchdog configuration pin states
	localparam logic [1:0] WDC_GROUND = 2'h0;
	localparam logic [1:0] WDC_RESISTOR = 2'h1;

	// Positions in the synchronised pin vector
	localparam int SX_VDDL = 0;
	localparam int SX_REGOT = 1;
	localparam int SX_OV = 2;
	localparam int SX_PW = 3;
	localparam int SX_LINF = 4;
	localparam int SX_OC = 7;
	localparam int SX_HSOT = 8;
	localparam int SX_LSOT = 9;
	localparam int SX_RST = 10;
	localparam int SX_CS = 11;
	localparam int SX_WAKE = 12;
	localparam int SX_PWM = 14;
	localparam int SX_HSOL = 15;
	localparam int SX_HSCL = 16;
	localparam int SX_WDC = 17;
	localparam int NSYNC = 19;
	// Synchroniser value after reset: every pin idle, so no false event or edge follows reset
	localparam logic [NSYNC-1:0] SYNC_IDLE = (NSYNC'(1) << SX_RST) | (NSYNC'(1) << SX_CS);

	// Wake source bits: wake input, LIN, timer
	localparam int WS_LX = 0;
	localparam int WS_LIN = 1;
	localparam int WS_TMR = 2;

	typedef enum logic [2:0] {
		M_RESET = 3'h0,
		M_NREQ = 3'h1,
		M_NORMAL = 3'h3,
		M_STOP = 3'h2,
		M_SLEEP = 3'h6
	} srw_mode_t;

endpackage

// [logic/srw_lin_wake.sv]
`timescale 1ns/1ns
module srw_lin_wake import srw_pkg::*; #(
	parameter logic [15:0] FILT = LIN_WAKE_CYC_DEF
) (
	input wire logic i_lin_clk,
	input wire logic i_lin_rst,
	input wire logic i_lin_rx,
	input wire logic i_arm,
	output logic o_wake_tgl
);

	typedef struct packed {
		logic rx1;
		logic rx2;
		logic arm1;
		logic arm2;
		logic [15:0] cnt;
		logic long_dom;
		logic tgl;
	} srw_lw_t;

	srw_lw_t q, n;

	////////////////////////////////////////////////////////////////////////
	// Dominant length filter; a bus stuck low never produces the edge
	always_comb begin
		n = q;
		n.rx1 = i_lin_rx;
		n.rx2 = q.rx1;
		n.arm1 = i_arm;
		n.arm2 = q.arm1;
		if (!q.arm2) begin
			n.cnt = 16'h0000;
			n.long_dom = 1'b0;
		end else if (!q.rx2) begin
			if (q.cnt == FILT)
				n.long_dom = 1'b1;
			else
				n.cnt = q.cnt + 16'h0001;
		end else begin
			if (q.long_dom)
				n.tgl = ~q.tgl; // Event crosses as a toggle
			n.cnt = 16'h0000;
			n.long_dom = 1'b0;
		end
	end

	always_ff @(posedge i_lin_clk) begin
		if (i_lin_rst)
			q <= '{rx1: 1'b1, rx2: 1'b1, default: '0}; // Bus idles recessive
		else
			q <= n;
	end

	assign o_wake_tgl = q.tgl;

	default clocking cb @(posedge i_lin_clk); endclocking
	default disable iff (i_lin_rst);

	property p_lin_short;
		!q.long_dom && q.rx2 |=> $stable(q.tgl);
	endproperty
	a_lin_short: assert property (p_lin_short)
		else $error("LIN wake without long dominant");

endmodule

// [verif/srw_host_model.sv]
`timescale 1ns/1ns
module srw_host_model import srw_pkg::*; (
	input wire logic i_ref_clk,
	input wire logic i_rst_oe,
	input wire logic i_hold_low,
	output logic o_rst_wire,
	output logic o_mode_wr,
	output logic [1:0] o_mode_sel,
	output logic o_timing_wr,
	output logic [1:0] o_prescale,
	output logic o_cyc_sel,
	output logic [2:0] o_cyc_bits
);

////////////////////////////////////////////////////////////////////////////////
	// Pull-up on the reset wire; either party may pull it low
	assign o_rst_wire = !(i_rst_oe || i_hold_low);

	// Idle controls from time zero
	initial begin
		o_mode_wr = 1'b0;
		o_mode_sel = 2'h0;
		o_timing_wr = 1'b0;
		o_prescale = 2'h0;
		o_cyc_sel = 1'b0;
		o_cyc_bits = 3'h0;
	end

////////////////////////////////////////////////////////////////////////////////
	// Mode writes also service the watchdog, so the caller picks the moment
	task automatic write_mode(input logic [1:0] sel);
		@(posedge i_ref_clk);
		o_mode_wr <= 1'b1;
		o_mode_sel <= sel;
		@(posedge i_ref_clk);
		o_mode_wr <= 1'b0;
		#1;
	endtask

	// Timer setup comes before the low-power command; cyc enables the timer, the switch bit picks cyclic or forced
	task automatic write_timing(input logic [1:0] pre, input logic cyc, input logic [2:0] per);
		@(posedge i_ref_clk);
		o_timing_wr <= 1'b1;
		o_prescale <= pre;
		o_cyc_sel <= cyc;
		o_cyc_bits <= per;
		@(posedge i_ref_clk);
		o_timing_wr <= 1'b0;
		#1;
	endtask

endmodule

// [verif/test_sbc_reset_wakeup_watchdog.sv]
`timescale 1ns/1ns
module test_sbc_reset_wakeup_watchdog import srw_pkg::*; ;

	// Shortened counts so the run stays brief
	localparam int RST = 20;
	localparam int NREQ = 200;
	localparam int WDP = 100;
	localparam int CYU = 200;

	logic i_ref_clk = 1'b0;
	logic i_lin_clk = 1'b0;
	logic i_rst = 1'b1;
	logic i_lin_rst = 1'b1;
	logic lin_rx = 1'b1;
	logic vdd_low = 1'b0;
	logic [5:0] cond = 6'h00;
	logic [2:0] lin_faults = 3'h0;
	logic cs_n = 1'b1;
	logic [1:0] pins = 2'h0;
	logic pwm = 1'b0;
	logic [1:0] hs_diag = 2'h0;
	logic [1:0] cfg = WDC_GROUND;
	logic [1:0] wake_en = 2'h0;
	logic [1:0] mux = 2'h0;
	wire logic rst_lvl;
	logic hs_sw = 1'b0;
	logic pwm_sel = 1'b0;
	logic [2:0] rd = 3'h0;
	logic hold_low = 1'b0;
	wire logic rst_wire;
	wire logic mode_wr;
	wire logic [1:0] mode_sel;
	wire logic timing_wr;
	wire logic [1:0] pre;
	wire logic cyc_sel;
	wire logic [2:0] cyc_bits;
	wire logic oe;
	wire logic irq_n;
	wire logic [2:0] mode;
	wire logic reg_en;
	wire logic [5:0] flg;
	wire logic drv_en;
	wire logic [2:0] lin_flags;
	wire logic wd_off;
	wire logic wd_fault;
	wire logic [1:0] wstat;
	wire logic [2:0] wsrc;
	wire logic hs_out;
	wire logic [1:0] hs_flags;
	int failures = 0;
	int tests_run = 0;
	int waited = 0;

////////////////////////////////////////////////////////////////////////////////
	// Main clock, and an unrelated link clock
	always #2 i_ref_clk = ~i_ref_clk;

	initial begin
		#1;
		forever #6 i_lin_clk = ~i_lin_clk;
	end

	srw_host_model i_host (.i_ref_clk(i_ref_clk), .i_rst_oe(oe), .i_hold_low(hold_low),
		.o_rst_wire(rst_wire), .o_mode_wr(mode_wr), .o_mode_sel(mode_sel),
		.o_timing_wr(timing_wr), .o_prescale(pre), .o_cyc_sel(cyc_sel), .o_cyc_bits(cyc_bits));

	srw_core #(.RST_CYC(RST), .NREQ_CYC(NREQ), .WD_INT(WDP), .WD_EXT(WDP), .CYC_UNIT(CYU),
		.LIN_FILT(16'h0008)) i_dut (
		.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_lin_clk(i_lin_clk), .i_lin_rst(i_lin_rst),
		.i_lin_rx(lin_rx), .i_vdd_low(vdd_low), .i_reg_overtemp(cond[0]),
		.i_supply_overvoltage_level(cond[1]), .i_temp_prewarn(cond[2]),
		.i_lin_faults(lin_faults), .i_lin_overcurrent(cond[3]), .i_hs_overtemp(cond[4]),
		.i_ls_overtemp(cond[5]), .i_rst_pin(rst_wire), .i_cs_n(cs_n), .i_wake_input_pins(pins),
		.i_pwm_input_pin(pwm), .i_hs_open_load(hs_diag[1]), .i_hs_current_limit(hs_diag[0]),
		.i_watchdog_config_pin(cfg), .i_mode_wr(mode_wr), .i_mode_select_bits(mode_sel),
		.i_timing_wr(timing_wr), .i_wd_prescale(pre), .i_cyclic_or_watchdog_select(cyc_sel),
		.i_cyclic_period_bits(cyc_bits), .i_wake_input_enable(wake_en), .i_mux_select(mux),
		.i_highside_switch(hs_sw), .i_highside_pwm_select(pwm_sel), .i_status_rd(rd[0]),
		.i_lin_status_rd(rd[1]), .i_irq_ack(rd[2]), .o_rst_pin_out(rst_lvl), .o_rst_pin_oe(oe),
		.o_irq_n(irq_n), .o_mode(mode), .o_reg_enable(reg_en),
		.o_regulator_overtemp_flag(flg[0]), .o_supply_ov_flag(flg[1]), .o_prewarn_flag(flg[2]),
		.o_lin_drv_enable(drv_en), .o_lin_fault_flags(lin_flags),
		.o_lin_overcurrent_flag(flg[3]), .o_hs_ot_cause(flg[4]), .o_ls_ot_cause(flg[5]),
		.o_watchdog_off_flag(wd_off), .o_wd_config_fault(wd_fault), .o_wakeup_status(wstat),
		.o_wake_source(wsrc), .o_highside_switch(hs_out),
		.o_highside_open_load_flag(hs_flags[1]), .o_highside_current_limit_flag(hs_flags[0]));

////////////////////////////////////////////////////////////////////////////////
	task automatic print_verdict();
		$display("Comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Bounded wait for a mode; running out of the bound ends the run
	task automatic wait_mode(input logic [2:0] m, input int bound);
		waited = 0;
		while (mode !== m && waited < bound) begin
			@(posedge i_ref_clk);
			#1;
			waited++;
		end
		check("mode", {5'h00, mode}, {5'h00, m});
		if (mode !== m) begin
			print_verdict();
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge i_ref_clk);
		#1;
	endtask

	// Read and acknowledge strobes, one cycle wide
	task automatic strobe(input logic [2:0] v);
		@(posedge i_ref_clk);
		rd <= v;
		@(posedge i_ref_clk);
		rd <= 3'h0;
		#1;
	endtask

	task automatic do_reset();
		@(posedge i_ref_clk);
		i_rst <= 1'b1;
		i_lin_rst <= 1'b1;
		repeat (2) @(posedge i_ref_clk);
		i_rst <= 1'b0;
		repeat (2) @(posedge i_ref_clk);
		i_lin_rst <= 1'b0;
		#1;
	endtask

	task automatic go_normal(input logic [1:0] p);
		wait_mode(M_NREQ, 40);
		i_host.write_timing(p, 1'b0, 3'h0);
		i_host.write_mode(MSEL_NORMAL);
		wait_mode(M_NORMAL, 1);
	endtask

	task automatic go_stop();
		go_normal(2'h0);
		i_host.write_mode(MSEL_STOP);
		wait_mode(M_STOP, 1);
	endtask

////////////////////////////////////////////////////////////////////////////////
	// Grounded config pin first: no watchdog, so long checks cannot trip it
	initial begin
		do_reset();
		check("rst oe", oe, 1);
		check("rst level", rst_lvl, 0);
		step(RST - 8);
		check("still reset", mode, M_RESET);
		wait_mode(M_NORMAL, 20);
		check("rst oe off", oe, 0);
		check("wd off", wd_off, 1);
		@(posedge i_ref_clk) hs_sw <= 1'b1;
		step(5);
		check("hs on", hs_out, 1);
		@(posedge i_ref_clk) pwm_sel <= 1'b1;
		step(5);
		check("hs pwm low", hs_out, 0);
		@(posedge i_ref_clk) pwm <= 1'b1;
		hs_diag <= 2'h3;
		step(5);
		check("hs pwm high", hs_out, 1);
		check("hs status", hs_flags, 3);
		@(posedge i_ref_clk) hs_sw <= 1'b0;
		for (int k = 0; k < 6; k++) begin
			@(posedge i_ref_clk) cond <= 6'h01 << k;
			step(6);
			check("flags", flg, 8'h01 << k);
			if (k == 0) check("reg en", reg_en, 0);
			if (k == 3) check("lin drv kept", drv_en, 1);
			if (k != 0) check("irq set", irq_n, 0);
			@(posedge i_ref_clk) cond <= 6'h00;
			step(6);
			strobe(3'h7);
			step(2);
			check("flags clear", flg, 0);
			check("irq clear", irq_n, 1);
		end
		for (int j = 0; j < 3; j++) begin
			@(posedge i_ref_clk) lin_faults <= 3'h1 << j;
			step(6);
			check("lin drv off", drv_en, 0);
			check("lin flag", lin_flags, 3'h1 << j);
			@(posedge i_ref_clk) lin_faults <= 3'h0;
			step(6);
			check("lin drv held", drv_en, 0);
			strobe(3'h6);
			step(2);
			check("lin drv back", drv_en, 1);
		end
		i_host.write_mode(MSEL_STOP);
		wait_mode(M_STOP, 1);
		@(posedge i_ref_clk) hold_low <= 1'b1;
		step(30);
		check("ext rst", mode, M_RESET);
		check("ext oe", oe, 0);
		@(posedge i_ref_clk) hold_low <= 1'b0;
		wait_mode(M_NORMAL, RST - 8);
		check("ext irq", irq_n, 1);
		// Open config pin: internal timebase, request mode in use
		@(posedge i_ref_clk) cfg <= 2'h2;
		do_reset();
		wait_mode(M_NREQ, RST + 10);
		check("cfg fault", wd_fault, 1);
		wait_mode(M_RESET, NREQ + 20);
		check("nreq late", waited > NREQ - 20, 1);
		go_normal(2'h0);
		i_host.write_mode(MSEL_NORMAL);
		wait_mode(M_RESET, 4);
		go_normal(2'h0);
		step(WDP / 2 + 10);
		i_host.write_mode(MSEL_NORMAL);
		check("open clear", mode, M_NORMAL);
		wait_mode(M_RESET, WDP + 10);
		check("wd late", waited > WDP - 20, 1);
		go_normal(2'h1);
		step(WDP + 20);
		i_host.write_mode(MSEL_NORMAL);
		check("prescale", mode, M_NORMAL);
		@(posedge i_ref_clk) vdd_low <= 1'b1;
		step(6);
		check("vdd rst", mode, M_RESET);
		check("vdd oe", oe, 1);
		@(posedge i_ref_clk) vdd_low <= 1'b0;
		wait_mode(M_NREQ, RST + 10);
		check("stretch", waited > RST - 6, 1);
		// Disabled or multiplexed input must not wake; chip-select rise wakes silently
		@(posedge i_ref_clk) wake_en <= 2'h1;
		mux <= 2'h1;
		cs_n <= 1'b0;
		go_stop();
		@(posedge i_ref_clk) pins <= 2'h3;
		step(20);
		check("masked wake", mode, M_STOP);
		check("wake status", wstat, 3);
		@(posedge i_ref_clk) cs_n <= 1'b1;
		wait_mode(M_NREQ, 8);
		check("cs irq", irq_n, 1);
		check("cs source", wsrc, 0);
		@(posedge i_ref_clk) mux <= 2'h0;
		go_stop();
		@(posedge i_ref_clk) pins <= 2'h2;
		wait_mode(M_NREQ, 10);
		check("lx irq", irq_n, 0);
		check("lx source", wsrc[0], 1);
		strobe(3'h7);
		go_normal(2'h0);
		i_host.write_timing(2'h0, 1'b1, 3'h0);
		i_host.write_mode(MSEL_STOP);
		wait_mode(M_NREQ, CYU + 30);
		check("timed late", waited > CYU - 50, 1);
		check("timed source", wsrc[2], 1);
		check("timed irq", irq_n, 0);
		strobe(3'h7);
		go_normal(2'h0);
		i_host.write_mode(MSEL_SLEEP);
		wait_mode(M_SLEEP, 1);
		// A dominant pulse shorter than the filter must not wake
		step(10);
		@(posedge i_ref_clk) lin_rx <= 1'b0;
		step(2);
		@(posedge i_ref_clk) lin_rx <= 1'b1;
		step(20);
		check("lin glitch", mode, M_SLEEP);
		// Bus held dominant must not wake until it returns recessive
		@(posedge i_ref_clk) lin_rx <= 1'b0;
		step(100);
		check("lin short", mode, M_SLEEP);
		@(posedge i_ref_clk) lin_rx <= 1'b1;
		wait_mode(M_RESET, 20);
		check("sleep oe", oe, 1);
		check("sleep reg", reg_en, 1);
		check("lin source", wsrc[1], 1);
		print_verdict();
	end

endmodule
